// File: core/lrms_consts.svh
// Constants for the display reset and operating-mode sequencer.
// Assumes a 50 MHz core clock and a 32-bit classic Wishbone slave port.
//
// Overview of operation
// - Power-on waits about 5 ms, then resets
// - Reset command or low pin starts reset
// - Reset sets Reset mode and default registers
// - Mode code: 00 Reset, 10 Sleep, 11 Normal
// - Clock, drivers and pump run only in Normal
// - Drain circuit on in Reset and Sleep
// - Only resets and display enable change mode
// - Driver enable bit picks Sleep or Normal
// - Display enable changes mode on internal clock; host waits 10 us
// - Sleep keeps user register values
// - Drivers idle until panel and bias ready
// - No panel drain without internal panel supply
`ifndef LRMS_CONSTS_SVH
`define LRMS_CONSTS_SVH

// ==========================================================
// Timing
`define LRMS_CLK_MHZ 50
`define LRMS_POR_WAIT_US 5000
`define LRMS_POR_WAIT_CYC (`LRMS_POR_WAIT_US * `LRMS_CLK_MHZ)
`define LRMS_TICK_DIV 50

// ==========================================================
// Register offsets (byte addresses)
`define LRMS_CMD_OFS 8'h00
`define LRMS_CONFIG_OFS 8'h04
`define LRMS_STATUS_OFS 8'h08

// ==========================================================
// Field positions
`define LRMS_CMD_SYSRST_BIT 0
`define LRMS_CMD_DISPWR_BIT 1
`define LRMS_CMD_DISPVAL_BIT 2
`define LRMS_DC_DRVEN_BIT 2

// ==========================================================
// Mode codes and reset values
`define LRMS_MODE_RESET 2'h0
`define LRMS_MODE_SLEEP 2'h2
`define LRMS_MODE_NORMAL 2'h3
`define LRMS_BIAS_RST 2'h0
`define LRMS_POT_RST 8'h40
`define LRMS_INTSUP_RST 1'h1
`define LRMS_DC_RST 3'h0

`endif

// File: core/lrms_pkg.sv
// Types shared by the sequencer and its surroundings.
// Assumes the constants header is compiled alongside.
package lrms_pkg;

   // ==========================================================
   // Power resource controls, all registered
   typedef struct packed {
      logic intClkRun;     // Internal clock running
      logic rowDrivers;    // Row drivers active
      logic columnDrivers; // Column drivers active
      logic chargePump;    // Charge pump on
      logic panelDrain;    // Panel supply drain on
      logic biasDrain;     // Bias capacitor drain on
   } lrms_power_type;

   // ==========================================================
   // User-written control settings
   typedef struct packed {
      logic [1:0] biasRatioSetting;   // Bias ratio
      logic [7:0] contrastPotSetting; // Contrast potentiometer
      logic intPanelSupply;           // Internal panel supply in use
      logic [2:0] displayCtrlField;   // Display control bits
   } lrms_setting_type;

   // ==========================================================
   // Sequencer states
   typedef enum logic [1:0] {
      ST_POR_WAIT,
      ST_SYS_RESET,
      ST_RUN
   } lrms_state_type;

   // Register select decode
   typedef enum logic [1:0] {
      SEL_CMD,
      SEL_CONFIG,
      SEL_STATUS,
      SEL_NONE
   } lrms_sel_type;

endpackage

// File: core/lrms_sequencer.sv
// Reset and operating-mode sequencer with a classic Wishbone slave.
// Assumes one 50 MHz clock; reset_n is the logic-supply power-on reset,
// the reset pin and analog ready flags arrive asynchronously.
`timescale 1ns/10ps
`default_nettype none
`include "lrms_consts.svh"

module lrms_sequencer #(
   parameter int POR_WAIT_CYC = `LRMS_POR_WAIT_CYC,
   parameter int TICK_DIV = `LRMS_TICK_DIV
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic resetPinN,
   input wire logic panelVoltReady,
   input wire logic biasVoltReady,
   output logic [1:0] opModeCode,
   output lrms_pkg::lrms_power_type powerCtl,
   output lrms_pkg::lrms_setting_type settings
);
   import lrms_pkg::*;

   localparam int PW = $clog2(POR_WAIT_CYC + 1);
   localparam int TW = $clog2(TICK_DIV + 1);

   // ==========================================================
   // Helper functions

   // Address decode, shared by read and write paths
   function automatic lrms_sel_type regSel(input logic [7:0] adr);
      lrms_sel_type s;
      s = SEL_NONE;
      if (adr == `LRMS_CMD_OFS) begin
         s = SEL_CMD;
      end else if (adr == `LRMS_CONFIG_OFS) begin
         s = SEL_CONFIG;
      end else if (adr == `LRMS_STATUS_OFS) begin
         s = SEL_STATUS;
      end
      return s;
   endfunction

   // Factory defaults of every control register
   function automatic lrms_setting_type defaults();
      lrms_setting_type d;
      d.biasRatioSetting = `LRMS_BIAS_RST;
      d.contrastPotSetting = `LRMS_POT_RST;
      d.intPanelSupply = `LRMS_INTSUP_RST;
      d.displayCtrlField = `LRMS_DC_RST;
      return d;
   endfunction

   // ==========================================================
   // Input synchronisers: three stages each
   // Bit 0 reset pin, bit 1 panel ready, bit 2 bias ready
   logic [2:0] syncA_q; // First stage, read only by second
   logic [2:0] syncB_q; // Second stage
   logic [2:0] syncC_q; // Third stage
   logic [2:0] pinFilt_q; // Accepted levels
   logic [2:0] pinFilt_d;

   // Change accepted only once stages two and three agree
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         pinFilt_d[i] = (syncB_q[i] == syncC_q[i]) ? syncC_q[i]
                                                    : pinFilt_q[i];
      end
   end

   // Sync registers; pin idles high, ready flags idle low
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         syncA_q <= 3'h1;
         syncB_q <= 3'h1;
         syncC_q <= 3'h1;
         pinFilt_q <= 3'h1;
      end else begin
         syncA_q <= {biasVoltReady, panelVoltReady, resetPinN};
         syncB_q <= syncA_q;
         syncC_q <= syncB_q;
         pinFilt_q <= pinFilt_d;
      end
   end

   logic pinResetLow; // Reset pin held low, clean
   logic panelRdy;    // Panel voltage ready, clean
   logic biasRdy;     // Bias voltage ready, clean
   assign pinResetLow = ~pinFilt_q[0];
   assign panelRdy = pinFilt_q[1];
   assign biasRdy = pinFilt_q[2];

   // ==========================================================
   // Internal clock edge divider
   logic [TW-1:0] tickCnt_q;
   logic [TW-1:0] tickCnt_d;
   logic tick; // One-cycle internal clock edge

   // Free-running so mode updates still land while asleep
   always_comb begin
      tick = (tickCnt_q == TW'(TICK_DIV - 1));
      tickCnt_d = tick ? '0 : tickCnt_q + TW'(1);
   end

   // Divider register
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         tickCnt_q <= '0;
      end else begin
         tickCnt_q <= tickCnt_d;
      end
   end

   // ==========================================================
   // Wishbone slave
   logic wbReq;       // Request present
   logic ack_q;
   logic ack_d;
   logic [31:0] rdat_q;
   logic [31:0] rdat_d;
   logic wrStrobe;    // Write lands at acknowledged edge
   lrms_sel_type sel; // Decoded register
   logic [31:0] statusWord;

   assign wbReq = wb_cyc_i & wb_stb_i;
   assign sel = regSel(wb_adr_i);
   assign wrStrobe = wbReq & wb_we_i & ack_q;

   logic cmdWr;    // Write to command register, low byte
   logic cmdSysRst; // System reset command
   logic cmdDisp;  // Display enable command
   assign cmdWr = wrStrobe & (sel == SEL_CMD) & wb_sel_i[0];
   assign cmdSysRst = cmdWr & wb_dat_i[`LRMS_CMD_SYSRST_BIT];
   assign cmdDisp = cmdWr & wb_dat_i[`LRMS_CMD_DISPWR_BIT];

   // Answer one cycle after request; unmapped reads zero
   always_comb begin
      ack_d = wbReq & ~ack_q;
      rdat_d = rdat_q;
      if (wbReq & ~ack_q) begin
         case (sel)
            SEL_CONFIG: begin
               rdat_d = {15'h0000, settings.intPanelSupply,
                         settings.contrastPotSetting,
                         6'h00, settings.biasRatioSetting};
            end
            SEL_STATUS: begin
               rdat_d = statusWord;
            end
            default: begin
               // Command register is write-only strobes
               rdat_d = 32'h00000000;
            end
         endcase
      end
   end

   // Bus answer registers
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_q <= 1'b0;
         rdat_q <= 32'h00000000;
      end else begin
         ack_q <= ack_d;
         rdat_q <= rdat_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   // ==========================================================
   // Sequencer: power-on wait, system reset, mode control
   lrms_state_type st_q;
   lrms_state_type st_d;
   logic [PW-1:0] porCnt_q;
   logic [PW-1:0] porCnt_d;
   logic [1:0] mode_q;
   logic [1:0] mode_d;
   logic pend_q; // Display enable seen, mode not yet updated
   logic pend_d;
   lrms_setting_type set_q;
   lrms_setting_type set_d;
   logic sysReq; // Any system reset source

   always_comb begin
      st_d = st_q;
      porCnt_d = porCnt_q;
      mode_d = mode_q;
      pend_d = pend_q;
      set_d = set_q;
      sysReq = pinResetLow | cmdSysRst;
      case (st_q)
         ST_POR_WAIT: begin
            // Supply settling; commands are ignored here
            if (porCnt_q == PW'(POR_WAIT_CYC - 1)) begin
               st_d = ST_SYS_RESET;
            end else begin
               porCnt_d = porCnt_q + PW'(1);
            end
         end
         ST_SYS_RESET: begin
            // Leave once the pin is up and a clock edge passes
            if (!pinResetLow && tick) begin
               st_d = ST_RUN;
            end
         end
         ST_RUN: begin
            // Apply pending mode on an internal clock edge
            if (pend_q && tick) begin
               mode_d = set_q.displayCtrlField[`LRMS_DC_DRVEN_BIT]
                        ? `LRMS_MODE_NORMAL : `LRMS_MODE_SLEEP;
               pend_d = 1'b0;
            end
            // Config write keeps mode unchanged
            if (wrStrobe && sel == SEL_CONFIG) begin
               if (wb_sel_i[0]) begin
                  set_d.biasRatioSetting = wb_dat_i[1:0];
               end
               if (wb_sel_i[1]) begin
                  set_d.contrastPotSetting = wb_dat_i[15:8];
               end
               if (wb_sel_i[2]) begin
                  set_d.intPanelSupply = wb_dat_i[16];
               end
            end
            // New command beats a same-cycle apply
            if (cmdDisp) begin
               set_d.displayCtrlField[`LRMS_DC_DRVEN_BIT] =
                  wb_dat_i[`LRMS_CMD_DISPVAL_BIT];
               pend_d = 1'b1;
            end
         end
         default: begin
            st_d = ST_SYS_RESET;
         end
      endcase
      // Reset entry overrides everything outside power-on wait
      if (sysReq && st_q != ST_POR_WAIT) begin
         st_d = ST_SYS_RESET;
         mode_d = `LRMS_MODE_RESET;
         set_d = defaults();
         pend_d = 1'b0;
      end
   end

   // Sequencer registers; Sleep never touches settings
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= ST_POR_WAIT;
         porCnt_q <= '0;
         mode_q <= `LRMS_MODE_RESET;
         pend_q <= 1'b0;
         set_q <= '{`LRMS_BIAS_RST, `LRMS_POT_RST,
                    `LRMS_INTSUP_RST, `LRMS_DC_RST};
      end else begin
         st_q <= st_d;
         porCnt_q <= porCnt_d;
         mode_q <= mode_d;
         pend_q <= pend_d;
         set_q <= set_d;
      end
   end

   assign opModeCode = mode_q;
   assign settings = set_q;

   // ==========================================================
   // Power resource controls
   lrms_power_type pwr_q;
   lrms_power_type pwr_d;
   logic isNormal;

   // Resources follow the mode; drivers also wait for ready
   always_comb begin
      isNormal = (mode_q == `LRMS_MODE_NORMAL);
      pwr_d.intClkRun = isNormal;
      pwr_d.chargePump = isNormal;
      // Drivers held idle until voltages are back
      pwr_d.rowDrivers = isNormal & panelRdy & biasRdy;
      pwr_d.columnDrivers = isNormal & panelRdy & biasRdy;
      pwr_d.biasDrain = ~isNormal;
      // Only the internal panel supply is drained by the system
      pwr_d.panelDrain = ~isNormal & set_q.intPanelSupply;
   end

   // Power registers; drains on from power-up for safety
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pwr_q <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
      end else begin
         pwr_q <= pwr_d;
      end
   end

   assign powerCtl = pwr_q;

   // ==========================================================
   // Status word
   assign statusWord = {13'h0000, set_q.displayCtrlField,
                        6'h00, pend_q, (st_q != ST_RUN),
                        biasRdy, panelRdy,
                        pwr_q.panelDrain, pwr_q.chargePump,
                        pwr_q.rowDrivers, pwr_q.intClkRun,
                        mode_q};

endmodule
`default_nettype wire

// File: sim/lrms_sequencer_assertions.sv
// Port checker for the display mode sequencer.
// Assumes it is bound onto lrms_sequencer; one clock domain.
`timescale 1ns/10ps
`default_nettype none
`include "lrms_consts.svh"
module lrms_sequencer_assertions #(
   parameter int TICK_DIV = 4
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_ack_o,
   input wire logic resetPinN,
   input wire logic panelVoltReady,
   input wire logic biasVoltReady,
   input wire logic [1:0] opModeCode,
   input wire lrms_pkg::lrms_power_type powerCtl,
   input wire lrms_pkg::lrms_setting_type settings
);
   import lrms_pkg::*;
   // ==========================================
   // Constants and helpers
   localparam lrms_setting_type DEF = {`LRMS_BIAS_RST, `LRMS_POT_RST,
      `LRMS_INTSUP_RST, `LRMS_DC_RST};
   // Tick wait plus register stages
   localparam int TMAX = TICK_DIV + 3;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // Display enable write at its ack edge
   logic enWr;
   assign enWr = wb_ack_o && wb_we_i && wb_adr_i == `LRMS_CMD_OFS
      && wb_dat_i[1] && !wb_dat_i[0] && wb_sel_i[0];
   // ==========================================
   // Properties
   property p_ack_one;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack not 1 cycle");
   property p_run_normal;
      $stable(opModeCode) |-> powerCtl.intClkRun == (opModeCode == 2'h3);
   endproperty
   a_run_normal: assert property (p_run_normal) else $error("clk");
   property p_drain;
      $stable(opModeCode) |-> powerCtl.biasDrain == (opModeCode != 2'h3);
   endproperty
   a_drain: assert property (p_drain) else $error("drain");
   property p_rows_ready;
      $rose(powerCtl.rowDrivers) |-> $past(panelVoltReady, 3)
         && $past(biasVoltReady, 3) && opModeCode == 2'h3;
   endproperty
   a_rows_ready: assert property (p_rows_ready) else $error("rows");
   property p_pin_reset;
      $fell(resetPinN) |-> ##[1:6] (opModeCode == 2'h0 && settings == DEF);
   endproperty
   a_pin_reset: assert property (p_pin_reset) else $error("pin");
   property p_to_normal;
      enWr && wb_dat_i[2] |-> ##[1:TMAX] opModeCode == 2'h3;
   endproperty
   a_to_normal: assert property (p_to_normal) else $error("normal");
   property p_to_sleep;
      enWr && !wb_dat_i[2] |-> ##[1:TMAX] opModeCode == 2'h2;
   endproperty
   a_to_sleep: assert property (p_to_sleep) else $error("sleep");
   property p_sleep_keep;
      opModeCode == 2'h2 && $past(opModeCode) == 2'h3 |-> $stable(settings);
   endproperty
   a_sleep_keep: assert property (p_sleep_keep) else $error("keep");
   property p_no_drain;
      powerCtl.panelDrain |-> settings.intPanelSupply
         || $past(settings.intPanelSupply);
   endproperty
   a_no_drain: assert property (p_no_drain) else $error("vdrain");
   c_normal: cover property (opModeCode == 2'h3);
   c_sleep: cover property (opModeCode == 2'h2);
   c_rows: cover property ($rose(powerCtl.rowDrivers));
endmodule
bind lrms_sequencer lrms_sequencer_assertions #(.TICK_DIV(TICK_DIV)) chk_u (.*);
`default_nettype wire

// File: sim/lrms_host_pins.sv
// Host side pins: reset pulse driver and supply ready flags.
// Assumes the charge pump control of the sequencer feeds it.
`timescale 1ns/10ps
`default_nettype none
module lrms_host_pins #(
   parameter int LOW_CYC = 150
) (
   input wire logic core_clk,
   input wire logic pinReq,
   input wire logic slow,
   input wire logic chargePump,
   output logic resetPinN,
   output logic panelVoltReady,
   output logic biasVoltReady
);
   // ==========================================
   // Pulse and ramp counters
   int lowCnt = 0;
   int rampCnt = 0;
   // Pin held low for 3 us at 50 MHz
   always @(posedge core_clk) begin
      if (pinReq) lowCnt <= LOW_CYC;
      else if (lowCnt > 0) lowCnt <= lowCnt - 1;
      // Ready drops at once when the pump stops
      if (!chargePump) rampCnt <= 0;
      else if (rampCnt < 40) rampCnt <= rampCnt + 1;
   end
   assign resetPinN = (lowCnt == 0);
   assign panelVoltReady = chargePump && rampCnt >= (slow ? 40 : 2);
   assign biasVoltReady = chargePump && rampCnt >= (slow ? 30 : 1);
endmodule
`default_nettype wire

// File: sim/lrms_sequencer_bench.sv
// Bench for the mode sequencer: bus tasks and mode scenarios.
// Assumes the bound checker and the host pin model are compiled.
`timescale 1ns/10ps
`default_nettype none
`include "lrms_consts.svh"
module lrms_sequencer_bench;
   import lrms_pkg::*;
   // ==========================================
   // Signals
   localparam logic [7:0] CM = `LRMS_CMD_OFS;
   localparam logic [7:0] CF = `LRMS_CONFIG_OFS;
   localparam logic [7:0] ST = `LRMS_STATUS_OFS;
   localparam logic [31:0] ALL = 32'hFFFF_FFFF;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic req = 1'b0, we = 1'b0, pinReq = 1'b0, slow = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0, q;
   logic [31:0] wbDatO;
   logic wbAck, rstPinN, pRdy, bRdy;
   logic [1:0] mode;
   lrms_power_type pwr;
   lrms_setting_type set;
   int n_errors = 0;
   int checked = 0;
   initial forever #10 core_clk = ~core_clk;
   lrms_sequencer #(.POR_WAIT_CYC(20), .TICK_DIV(4)) dut_u (
      .core_clk(core_clk), .reset_n(reset_n), .wb_cyc_i(req),
      .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat),
      .wb_sel_i(4'hF), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
      .resetPinN(rstPinN), .panelVoltReady(pRdy), .biasVoltReady(bRdy),
      .opModeCode(mode), .powerCtl(pwr), .settings(set));
   lrms_host_pins hostU (.core_clk(core_clk), .pinReq(pinReq),
      .slow(slow), .chargePump(pwr.chargePump), .resetPinN(rstPinN),
      .panelVoltReady(pRdy), .biasVoltReady(bRdy));
   // ==========================================
   // Tasks
   task automatic tally_and_finish();
      if (n_errors == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // One classic cycle; request held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      int i;
      @(posedge core_clk);
      req <= 1'b1;
      {we, adr, dat} <= {w, a, d};
      i = 0;
      do begin
         @(posedge core_clk);
         i++;
      end while (wbAck !== 1'b1 && i < 20);
      q = wbDatO;
      req <= 1'b0;
      if (wbAck !== 1'b1) begin
         n_errors++;
         tally_and_finish();
      end
   endtask
   // Read until the masked value matches, bounded
   task automatic rdChk(input logic [7:0] a, input logic [31:0] m,
         input logic [31:0] v);
      int i;
      for (i = 0; i < 100; i++) begin
         wb(1'b0, a, 32'h0);
         if ((q & m) === v) break;
      end
      chk(q & m, v);
      if ((q & m) !== v) tally_and_finish();
   endtask
   // ==========================================
   // Scenarios
   initial begin
      repeat (5) @(posedge core_clk);
      reset_n <= 1'b1;
      rdChk(ST, 32'h103, 32'h100);
      rdChk(ST, 32'h103, 32'h0);
      repeat (20) @(posedge core_clk);
      rdChk(CF, ALL, 32'h0001_4000);
      rdChk(CM, ALL, 32'h0);
      slow <= 1'b1;
      wb(1'b1, CF, 32'h0001_5502);
      wb(1'b1, CM, 32'h6);
      rdChk(ST, 32'h3, 32'h3);
      // Single read: the slow ramp keeps the drivers idle for now
      wb(1'b0, ST, 32'h0);
      chk(q & 32'h8, 32'h0);
      rdChk(ST, 32'h3F, 32'h1F);
      chk({30'h0, pwr.columnDrivers, pwr.biasDrain}, 32'h2);
      wb(1'b1, CF, 32'h0001_7702);
      rdChk(ST, 32'h3, 32'h3);
      wb(1'b1, 8'h10, ALL);
      rdChk(8'h10, ALL, 32'h0);
      wb(1'b1, CM, 32'h2);
      rdChk(ST, 32'h3, 32'h2);
      rdChk(ST, 32'h3C, 32'h20);
      chk({30'h0, pwr.columnDrivers, pwr.biasDrain}, 32'h1);
      chk({30'h0, mode}, 32'h2);
      rdChk(CF, ALL, 32'h0001_7702);
      chk({18'h0, set}, {18'h0, 2'h2, 8'h77, 1'b1, 3'h0});
      wb(1'b1, CF, 32'h0000_7702);
      rdChk(ST, 32'h20, 32'h0);
      wb(1'b1, CM, 32'h1);
      rdChk(ST, 32'h103, 32'h0);
      rdChk(CF, ALL, 32'h0001_4000);
      slow <= 1'b0;
      wb(1'b1, CF, 32'h0001_5502);
      wb(1'b1, CM, 32'h6);
      rdChk(ST, 32'h3F, 32'h1F);
      @(posedge core_clk);
      pinReq <= 1'b1;
      @(posedge core_clk);
      pinReq <= 1'b0;
      rdChk(ST, 32'h103, 32'h0);
      rdChk(CF, ALL, 32'h0001_4000);
      wb(1'b1, CM, 32'h6);
      rdChk(ST, 32'h3, 32'h3);
      wb(1'b1, CM, 32'h1);
      rdChk(ST, 32'h23, 32'h20);
      tally_and_finish();
   end
endmodule
`default_nettype wire
